// file: design/mcs_regs.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 32-bit APB, one aligned word per register
// Notes:   definitions only
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
// register byte offsets
`define MCS_OFS_CTRL       8'h00
`define MCS_OFS_TCS_DELAY  8'h04
`define MCS_OFS_LOP_DELAY  8'h08
`define MCS_OFS_CTS_DELAY  8'h0C
`define MCS_OFS_BASE_DEV   8'h10
`define MCS_OFS_DYN_FACTOR 8'h14
`define MCS_OFS_RATE_PHASE 8'h18
`define MCS_OFS_RATE_EARTH 8'h1C
`define MCS_OFS_OC_MASK    8'h20
`define MCS_OFS_ELEM_MASK  8'h24
`define MCS_OFS_VOLT_NOM   8'h28
`define MCS_OFS_CUR_RATED  8'h2C
`define MCS_OFS_UNDERCUR   8'h30
`define MCS_OFS_STATUS     8'h34
`define MCS_OFS_EARTH_FACT 8'h38
// control field positions
`define MCS_CTRL_TCS_EN    0
`define MCS_CTRL_TCS_TWO   1
`define MCS_CTRL_BRK_ASGN  2
`define MCS_CTRL_CTS_EN    3
`define MCS_CTRL_LOP_EN    4
`define MCS_CTRL_BLK_EN    5
`define MCS_CTRL_FUSE_ASGN 6
`define MCS_CTRL_SIDE_SEL  7
// reset values
`define MCS_RST_CTRL       16'h0000
`define MCS_RST_DELAY      16'h0000
// timing: delay settings count in milliseconds
`define MCS_TICK_US        1000
`define MCS_CLK_KHZ        50000
`define MCS_MS_CYCLES      ((`MCS_TICK_US * `MCS_CLK_KHZ) / 1000)
// thresholds and scaling
`define MCS_PCT_FULL       8'h64
`define MCS_NEG_RATIO_PCT  8'h28
`define MCS_LOWV_PCT       8'h01
`define MCS_TENTHS_FULL    8'h0A
`define MCS_RESID_TENTHS   8'h01
`define MCS_DIV_STEPS      6'h28
`endif

// file: design/mcs_pkg.sv
// Purpose: state types of the supervision block
// Assumes: widths fixed
// Notes:   constants live in mcs_regs.svh
package mcs_pkg;
  typedef struct packed {
    logic [15:0] pres;
    logic [15:0] ms;
    logic        alarm;
  } mcs_tmr_s;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] tcs_delay;
    logic [15:0] lop_delay;
    logic [15:0] cts_delay;
    logic [15:0] base_dev;
    logic [15:0] dyn_factor;
    logic [31:0] rate_phase;
    logic [31:0] rate_earth;
    logic [7:0]  oc_mask;
    logic [15:0] elem_mask;
    logic [15:0] volt_nom;
    logic [15:0] cur_rated;
    logic [15:0] undercur;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] elem_block;
    logic        cts_err;
    logic [40:0] rem;
    logic [39:0] quo;
    logic [31:0] den;
    logic [5:0]  div_cnt;
    logic        div_busy;
    logic        div_start;
    logic [15:0] earth_factor;
  } mcs_top_s;
endpackage

// file: design/mcs_tmr_if.sv
// Purpose: condition, delay and alarm of one supervision timer
// Assumes: one clock
// Notes:   owner drives cond and delay
`timescale 1ns/1ps
interface mcs_tmr_if;
  logic        cond;
  logic [15:0] delay_ms;
  logic        alarm;
  modport owner (output cond, output delay_ms, input alarm);
  modport timer (input cond, input delay_ms, output alarm);
endinterface

// file: design/mcs_phase_mag.sv
// Purpose: sum and largest magnitude of three signed phase samples
// Assumes: 16-bit two's complement samples, packed a-b-c from bit 0
// Notes:   purely combinational
`timescale 1ns/1ps
module mcs_phase_mag (
  // samples
  input  wire logic [47:0]        samples,
  // results
  output logic signed [17:0]      sum,
  output logic [16:0]             max_abs
);
  logic [16:0] mag [3];

  // magnitude per phase, one bit wider so -32768 fits
  for (genvar i = 0; i < 3; i++) begin : g_mag
    logic signed [15:0] s;
    assign s      = samples[16*i +: 16];
    assign mag[i] = s[15] ? 17'(-$signed({s[15], s})) : {1'b0, s};
  end

  // residual and maximum
  assign sum = 18'($signed(samples[15:0])) + 18'($signed(samples[31:16])) + 18'($signed(samples[47:32]));
  assign max_abs = (mag[0] >= mag[1]) ? ((mag[0] >= mag[2]) ? mag[0] : mag[2])
                                      : ((mag[1] >= mag[2]) ? mag[1] : mag[2]);
endmodule

// file: design/mcs_timer.sv
// Purpose: millisecond pickup delay for one supervision alarm
// Assumes: delay_ms may be zero
// Notes:   restarts from zero whenever cond drops
`timescale 1ns/1ps
`include "mcs_regs.svh"
module mcs_timer #(
  parameter int unsigned MS_CYCLES = `MCS_MS_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // condition and alarm
  mcs_tmr_if.timer  tif
);
  mcs_pkg::mcs_tmr_s st_reg;
  mcs_pkg::mcs_tmr_s st_next;

  // prescaler then ms count; cleared at once when the fault goes
  always_comb begin
    st_next = st_reg;
    if (!tif.cond) begin
      st_next = '0;
    end else if (st_reg.ms >= tif.delay_ms) begin
      st_next.alarm = 1'b1;
    end else if (st_reg.pres == 16'(MS_CYCLES - 1)) begin
      st_next.pres = '0;
      st_next.ms   = st_reg.ms + 16'h0001;
    end else begin
      st_next.pres = st_reg.pres + 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tif.alarm = st_reg.alarm;

  AST_TMR_CLEAR: assert property (@(posedge clock) disable iff (reset)
    !tif.cond |=> !tif.alarm)
    else $error("alarm stayed after condition cleared");
  AST_TMR_HOLD: assert property (@(posedge clock) disable iff (reset)
    (tif.alarm && tif.cond) |=> tif.alarm)
    else $error("alarm dropped while condition held");
endmodule

// file: design/mcs_top.sv
// Purpose: trip circuit, CT and loss-of-potential supervision with APB registers
// Assumes: measured quantities synchronous to CLOCK, already scaled
// Notes:   one wait state on every APB access
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "mcs_regs.svh"

// Operation
// - one contact: supervise only breaker closed
// - two contacts: supervise always with supply
// - trip circuit alarm only after delay
// - supply loss counts as circuit failure
// - compare computed residual with earth current
// - derive earth factor from transformer ratings
// - limit is base plus factor times Imax
// - correction term rises linearly with current
// - potential loss uses voltages, currents, pickups
// - block alarm after potential loss delay
// - assigned overcurrent pickups inhibit detection
// - potential loss blocking propagates only when enabled
// - only opted-in elements get blocked
// - fuse failure from assigned digital input
// - fuse failure blocks opted-in elements
// - use currents of selected winding side
// - low phase voltage plus ratio or V0
// - low residual current, breaker closed if assigned
module mcs_top #(
  parameter int unsigned MS_CYCLES = `MCS_MS_CYCLES
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // breaker inputs
  input  wire logic        BREAKER_CLOSED_CONTACT,
  input  wire logic        BREAKER_OPEN_CONTACT,
  input  wire logic        BREAKER_POSITION_CLOSED,
  // current samples, three signed phases per side
  input  wire logic [47:0] CUR_SIDE0,
  input  wire logic [47:0] CUR_SIDE1,
  input  wire logic [15:0] EARTH_CUR,
  // voltage magnitudes
  input  wire logic [47:0] VOLT_PHASE,
  input  wire logic [15:0] VOLT_POS,
  input  wire logic [15:0] VOLT_NEG,
  input  wire logic [15:0] VOLT_ZERO,
  // protection interface
  input  wire logic [7:0]  OC_PICKUP,
  input  wire logic        FUSE_FAILURE_INPUT,
  output logic             TRIP_CIRCUIT_ALARM,
  output logic             CT_ALARM,
  output logic             POTENTIAL_LOSS_BLOCK,
  output logic [15:0]      ELEMENT_BLOCK
);
  mcs_pkg::mcs_top_s st_reg;
  mcs_pkg::mcs_top_s st_next;

  mcs_tmr_if tcs_if ();
  mcs_tmr_if cts_if ();
  mcs_tmr_if lop_if ();

  logic               acc;
  logic               hit;
  logic               ro;
  logic [31:0]        rd_mux;
  logic [31:0]        status;
  logic signed [17:0] sum0;
  logic signed [17:0] sum1;
  logic [16:0]        max0;
  logic [16:0]        max1;
  logic signed [32:0] earth_prod;
  logic signed [33:0] resid_total;
  logic [33:0]        resid_abs;
  logic [32:0]        dyn_prod;
  logic [33:0]        cts_limit;
  logic [40:0]        div_shift;
  logic               div_fit;
  logic               tcs_cond;
  logic               lop_cond;
  logic               fuse_active;
  logic               oc_block;
  logic               low_phase_v;
  logic               ratio_hi;
  logic               low_v0;
  logic signed [17:0] lop_sum;
  logic [16:0]        lop_max;
  logic [17:0]        lop_resid;
  logic               brk_ok;

  function automatic logic [25:0] scale(input logic [17:0] v, input logic [7:0] k);
    return 26'(v) * 26'(k);
  endfunction

  // phase sums and maxima of both winding sides
  mcs_phase_mag u_mag0 (
    .samples (CUR_SIDE0),
    .sum     (sum0),
    .max_abs (max0)
  );
  mcs_phase_mag u_mag1 (
    .samples (CUR_SIDE1),
    .sum     (sum1),
    .max_abs (max1)
  );

  // apb decode; request held by the master until pready
  assign acc = PSEL && PENABLE;
  assign ro  = (PADDR == `MCS_OFS_STATUS) || (PADDR == `MCS_OFS_EARTH_FACT);

  assign status = {25'h000_0000, st_reg.div_busy, tcs_cond, lop_cond, fuse_active,
                   POTENTIAL_LOSS_BLOCK, CT_ALARM, TRIP_CIRCUIT_ALARM};

  // read mux; unmapped reads give zero and an error
  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `MCS_OFS_CTRL:       rd_mux = {16'h0000, st_reg.ctrl};
      `MCS_OFS_TCS_DELAY:  rd_mux = {16'h0000, st_reg.tcs_delay};
      `MCS_OFS_LOP_DELAY:  rd_mux = {16'h0000, st_reg.lop_delay};
      `MCS_OFS_CTS_DELAY:  rd_mux = {16'h0000, st_reg.cts_delay};
      `MCS_OFS_BASE_DEV:   rd_mux = {16'h0000, st_reg.base_dev};
      `MCS_OFS_DYN_FACTOR: rd_mux = {16'h0000, st_reg.dyn_factor};
      `MCS_OFS_RATE_PHASE: rd_mux = st_reg.rate_phase;
      `MCS_OFS_RATE_EARTH: rd_mux = st_reg.rate_earth;
      `MCS_OFS_OC_MASK:    rd_mux = {24'h00_0000, st_reg.oc_mask};
      `MCS_OFS_ELEM_MASK:  rd_mux = {16'h0000, st_reg.elem_mask};
      `MCS_OFS_VOLT_NOM:   rd_mux = {16'h0000, st_reg.volt_nom};
      `MCS_OFS_CUR_RATED:  rd_mux = {16'h0000, st_reg.cur_rated};
      `MCS_OFS_UNDERCUR:   rd_mux = {16'h0000, st_reg.undercur};
      `MCS_OFS_STATUS:     rd_mux = status;
      `MCS_OFS_EARTH_FACT: rd_mux = {16'h0000, st_reg.earth_factor};
      default:             hit = 1'b0;
    endcase
  end

  // trip circuit: one contact only sees faults while closed;
  // two contacts both dark means broken circuit or lost supply
  always_comb begin
    tcs_cond = 1'b0;
    if (st_reg.ctrl[`MCS_CTRL_TCS_EN] && st_reg.ctrl[`MCS_CTRL_BRK_ASGN]) begin
      if (st_reg.ctrl[`MCS_CTRL_TCS_TWO]) begin
        tcs_cond = !BREAKER_CLOSED_CONTACT && !BREAKER_OPEN_CONTACT;
      end else begin
        tcs_cond = BREAKER_POSITION_CLOSED && !BREAKER_CLOSED_CONTACT;
      end
    end
  end

  // residual check; earth factor is 8.8 fixed point
  assign earth_prod  = $signed({1'b0, st_reg.earth_factor}) * $signed(EARTH_CUR);
  assign resid_total = 34'(sum0) + 34'(earth_prod >>> 8);
  assign resid_abs   = resid_total[33] ? 34'(-resid_total) : 34'(resid_total);
  // correction grows with the largest phase current
  assign dyn_prod    = {16'h0000, st_reg.dyn_factor} * {16'h0000, max0};
  assign cts_limit   = 34'(st_reg.base_dev) + 34'(dyn_prod >> 8);

  // ratio divider: shift-subtract, one quotient bit per cycle
  assign div_shift = {st_reg.rem[39:0], st_reg.quo[39]};
  assign div_fit   = div_shift >= {9'h000, st_reg.den};

  // loss of potential quantities from the selected winding
  assign lop_sum   = st_reg.ctrl[`MCS_CTRL_SIDE_SEL] ? sum1 : sum0;
  assign lop_max   = st_reg.ctrl[`MCS_CTRL_SIDE_SEL] ? max1 : max0;
  assign lop_resid = lop_sum[17] ? 18'(-lop_sum) : 18'(lop_sum);

  // voltage pattern of a lost VT rather than a fault
  assign low_phase_v = (scale({2'b00, VOLT_PHASE[15:0]}, `MCS_PCT_FULL) < scale({2'b00, st_reg.volt_nom}, `MCS_LOWV_PCT))
                    || (scale({2'b00, VOLT_PHASE[31:16]}, `MCS_PCT_FULL) < scale({2'b00, st_reg.volt_nom}, `MCS_LOWV_PCT))
                    || (scale({2'b00, VOLT_PHASE[47:32]}, `MCS_PCT_FULL) < scale({2'b00, st_reg.volt_nom}, `MCS_LOWV_PCT));
  assign ratio_hi = scale({2'b00, VOLT_NEG}, `MCS_PCT_FULL) > scale({2'b00, VOLT_POS}, `MCS_NEG_RATIO_PCT);
  assign low_v0   = scale({2'b00, VOLT_ZERO}, `MCS_PCT_FULL) < scale({2'b00, st_reg.volt_nom}, `MCS_LOWV_PCT);
  assign oc_block = |(OC_PICKUP & st_reg.oc_mask);
  assign brk_ok   = !st_reg.ctrl[`MCS_CTRL_BRK_ASGN] || BREAKER_POSITION_CLOSED;

  // all conditions must coincide; any pickup enabled in oc_mask vetoes
  assign lop_cond = st_reg.ctrl[`MCS_CTRL_LOP_EN] && low_phase_v && (ratio_hi || low_v0)
                 && (lop_max < {1'b0, st_reg.undercur})
                 && (scale(lop_resid, `MCS_TENTHS_FULL) < scale({2'b00, st_reg.cur_rated}, `MCS_RESID_TENTHS))
                 && !oc_block && brk_ok;

  // input high means the VT secondary breaker has opened
  assign fuse_active = st_reg.ctrl[`MCS_CTRL_FUSE_ASGN] && FUSE_FAILURE_INPUT;

  // next state: bus, divider, evaluation results
  always_comb begin
    st_next        = st_reg;
    st_next.pready = 1'b0;
    st_next.cts_err = st_reg.ctrl[`MCS_CTRL_CTS_EN] && (resid_abs >= cts_limit);
    // potential loss blocking gated by enable, fuse failure not; all by each element's own opt-in
    st_next.elem_block = st_reg.elem_mask
      & {16{(POTENTIAL_LOSS_BLOCK && st_reg.ctrl[`MCS_CTRL_BLK_EN]) || fuse_active}};
    if (st_reg.div_start) begin
      st_next.div_start = 1'b0;
      st_next.rem       = '0;
      st_next.quo       = {32'(st_reg.rate_earth[15:0]) * 32'(st_reg.rate_phase[31:16]), 8'h00};
      st_next.den       = 32'(st_reg.rate_phase[15:0]) * 32'(st_reg.rate_earth[31:16]);
      st_next.div_cnt   = `MCS_DIV_STEPS;
      st_next.div_busy  = 1'b1;
    end else if (st_reg.div_busy && (st_reg.div_cnt != 6'h00)) begin
      st_next.rem     = div_fit ? (div_shift - {9'h000, st_reg.den}) : div_shift;
      st_next.quo     = {st_reg.quo[38:0], div_fit};
      st_next.div_cnt = st_reg.div_cnt - 6'h01;
    end else if (st_reg.div_busy) begin
      // zero rating gives factor zero; overflow saturates
      st_next.div_busy = 1'b0;
      if (st_reg.den == 32'h0000_0000) begin
        st_next.earth_factor = 16'h0000;
      end else if (st_reg.quo[39:16] != 24'h00_0000) begin
        st_next.earth_factor = 16'hFFFF;
      end else begin
        st_next.earth_factor = st_reg.quo[15:0];
      end
    end
    // first access cycle: capture answer; second: commit
    if (acc && !st_reg.pready) begin
      st_next.pready  = 1'b1;
      st_next.prdata  = PWRITE ? 32'h0000_0000 : rd_mux;
      st_next.pslverr = !hit || (PWRITE && ro);
    end else if (acc && PWRITE && hit && !ro) begin
      case (PADDR)
        `MCS_OFS_CTRL:       st_next.ctrl = PWDATA[15:0];
        `MCS_OFS_TCS_DELAY:  st_next.tcs_delay = PWDATA[15:0];
        `MCS_OFS_LOP_DELAY:  st_next.lop_delay = PWDATA[15:0];
        `MCS_OFS_CTS_DELAY:  st_next.cts_delay = PWDATA[15:0];
        `MCS_OFS_BASE_DEV:   st_next.base_dev = PWDATA[15:0];
        `MCS_OFS_DYN_FACTOR: st_next.dyn_factor = PWDATA[15:0];
        `MCS_OFS_RATE_PHASE: begin
          st_next.rate_phase = PWDATA;
          st_next.div_start  = 1'b1;
        end
        `MCS_OFS_RATE_EARTH: begin
          st_next.rate_earth = PWDATA;
          st_next.div_start  = 1'b1;
        end
        `MCS_OFS_OC_MASK:    st_next.oc_mask = PWDATA[7:0];
        `MCS_OFS_ELEM_MASK:  st_next.elem_mask = PWDATA[15:0];
        `MCS_OFS_VOLT_NOM:   st_next.volt_nom = PWDATA[15:0];
        `MCS_OFS_CUR_RATED:  st_next.cur_rated = PWDATA[15:0];
        `MCS_OFS_UNDERCUR:   st_next.undercur = PWDATA[15:0];
        default:             st_next.ctrl = st_reg.ctrl;
      endcase
    end
  end

  // state register; divider runs once after reset
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      st_reg           <= '0;
      st_reg.ctrl      <= `MCS_RST_CTRL;
      st_reg.tcs_delay <= `MCS_RST_DELAY;
      st_reg.lop_delay <= `MCS_RST_DELAY;
      st_reg.cts_delay <= `MCS_RST_DELAY;
      st_reg.div_start <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // delay timers
  assign tcs_if.cond     = tcs_cond;
  assign tcs_if.delay_ms = st_reg.tcs_delay;
  assign cts_if.cond     = st_reg.cts_err;
  assign cts_if.delay_ms = st_reg.cts_delay;
  assign lop_if.cond     = lop_cond;
  assign lop_if.delay_ms = st_reg.lop_delay;

  mcs_timer #(.MS_CYCLES(MS_CYCLES)) u_tcs_tmr (
    .clock (CLOCK),
    .reset (RESET),
    .tif   (tcs_if.timer)
  );
  mcs_timer #(.MS_CYCLES(MS_CYCLES)) u_cts_tmr (
    .clock (CLOCK),
    .reset (RESET),
    .tif   (cts_if.timer)
  );
  mcs_timer #(.MS_CYCLES(MS_CYCLES)) u_lop_tmr (
    .clock (CLOCK),
    .reset (RESET),
    .tif   (lop_if.timer)
  );

  // outputs, all from flip-flops
  assign TRIP_CIRCUIT_ALARM   = tcs_if.alarm;
  assign CT_ALARM             = cts_if.alarm;
  assign POTENTIAL_LOSS_BLOCK = lop_if.alarm;
  assign ELEMENT_BLOCK        = st_reg.elem_block;
  assign PRDATA               = st_reg.prdata;
  assign PREADY               = st_reg.pready;
  assign PSLVERR              = st_reg.pslverr;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence brk_open_one_seq;
    (st_reg.ctrl[`MCS_CTRL_TCS_TWO] == 1'b0) && !BREAKER_POSITION_CLOSED [*2];
  endsequence
  sequence supply_lost_seq;
    st_reg.ctrl[`MCS_CTRL_TCS_EN] && st_reg.ctrl[`MCS_CTRL_BRK_ASGN] && st_reg.ctrl[`MCS_CTRL_TCS_TWO]
      && !BREAKER_CLOSED_CONTACT && !BREAKER_OPEN_CONTACT;
  endsequence

  AST_TCS_OPEN_QUIET: assert property (
    brk_open_one_seq |-> !TRIP_CIRCUIT_ALARM)
    else $error("trip circuit alarm with breaker open in one-contact mode");
  AST_TCS_SUPPLY_LOSS: assert property (
    supply_lost_seq |-> tcs_if.cond)
    else $error("lost trip supply not seen as fault");
  AST_TCS_DELAYED: assert property (
    $rose(TRIP_CIRCUIT_ALARM) |-> $past(tcs_cond) && ($past(u_tcs_tmr.st_reg.ms) >= $past(st_reg.tcs_delay)))
    else $error("trip circuit alarm before delay");
  AST_CTS_LIMIT: assert property (
    (st_reg.ctrl[`MCS_CTRL_CTS_EN] && (resid_abs >= cts_limit)) |=> (st_reg.cts_err && cts_if.cond))
    else $error("residual mismatch at limit not flagged");
  AST_CTS_CAUSE: assert property (
    $rose(CT_ALARM) |-> $past(st_reg.cts_err, 1))
    else $error("ct alarm without mismatch");
  AST_LOP_OC_VETO: assert property (
    oc_block |=> !POTENTIAL_LOSS_BLOCK)
    else $error("potential loss block during overcurrent pickup");
  AST_LOP_BRK_OPEN: assert property (
    (st_reg.ctrl[`MCS_CTRL_BRK_ASGN] && !BREAKER_POSITION_CLOSED) |=> !POTENTIAL_LOSS_BLOCK)
    else $error("potential loss block with breaker open");
  AST_LOP_CAUSE: assert property (
    $rose(POTENTIAL_LOSS_BLOCK) |-> $past(lop_cond))
    else $error("potential loss block without condition");
  AST_BLOCK_GATED: assert property (
    (!st_reg.ctrl[`MCS_CTRL_BLK_EN] && !fuse_active) |=> (ELEMENT_BLOCK == 16'h0000))
    else $error("blocking propagated while disabled");
  AST_BLOCK_MASK: assert property (
    1'b1 |=> ((ELEMENT_BLOCK & ~$past(st_reg.elem_mask)) == 16'h0000))
    else $error("element blocked without opt-in");
  AST_FUSE_BLOCK: assert property (
    fuse_active |=> (ELEMENT_BLOCK == $past(st_reg.elem_mask)))
    else $error("fuse failure did not block opted-in elements");
endmodule

// file: verification/mcs_brk_model.sv
// Purpose: breaker auxiliary contact loops seen by the trip circuit inputs
// Assumes: contacts follow the main poles one clock late
// Notes:   a lost supply or a broken wire de-energises both loops
`timescale 1ns/1ps
module mcs_brk_model (
  // clock
  input  wire logic clk,
  // breaker state and circuit health
  input  wire logic closed,
  input  wire logic supply_ok,
  input  wire logic wire_ok,
  // contact loops
  output logic      closed_loop,
  output logic      open_loop
);
  // lag models the status recognition time of the relay
  always_ff @(posedge clk) begin
    closed_loop <= supply_ok & wire_ok & closed;
    open_loop   <= supply_ok & wire_ok & ~closed;
  end
endmodule

// file: verification/testbench.sv
// Purpose: self-checking bench of the supervision block
// Assumes: MS_CYCLES of 4, so one ms is four clocks
// Notes:   alarm timing is checked inside a small window
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, psel, pen, pwr, fuse, brk, sup, wok, ccl, ocl;
  logic [7:0]  paddr, oc;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, tca, cta, plb;
  logic [47:0] is0, is1, vph;
  logic [15:0] ig, v0, v2, eb;
  int          error_cnt, num_checks, cyc = 0;

  mcs_brk_model u_brk (.clk(clk), .closed(brk), .supply_ok(sup), .wire_ok(wok),
                       .closed_loop(ccl), .open_loop(ocl));
  mcs_top #(.MS_CYCLES(4)) u_dut (.CLOCK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BREAKER_CLOSED_CONTACT(ccl), .BREAKER_OPEN_CONTACT(ocl),
    .BREAKER_POSITION_CLOSED(brk), .CUR_SIDE0(is0), .CUR_SIDE1(is1), .EARTH_CUR(ig),
    .VOLT_PHASE(vph), .VOLT_POS(16'h03E8), .VOLT_NEG(v2), .VOLT_ZERO(v0),
    .OC_PICKUP(oc), .FUSE_FAILURE_INPUT(fuse), .TRIP_CIRCUIT_ALARM(tca), .CT_ALARM(cta),
    .POTENTIAL_LOSS_BLOCK(plb), .ELEMENT_BLOCK(eb));

  // clock, and a ceiling far above the planned run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  // only the global cycle ceiling ends a wait that never completes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask

  // counts clocks until the chosen output rises, then judges the window
  // index 0 trip circuit, 1 potential loss, 2 ct, 3 any element block
  task automatic wt(input int k, input int lo, input int hi);
    int         n;
    logic [3:0] v;
    n = 0;
    v = {|eb, cta, plb, tca};
    while (v[k] !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
      v = {|eb, cta, plb, tca};
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic t_regs();
    chk({tca, cta, plb, eb}, 32'h0);
    apb(1, 8'h00, 32'hA5); apb(0, 8'h00, 32'h0); chk(rd, 32'hA5);
    apb(0, 8'h3C, 32'h0); chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1, 8'h34, 32'h7F); chk(32'(er), 32'h1);
    apb(1, 8'h18, 32'h0001_0064); apb(1, 8'h1C, 32'h0001_0032);
    repeat (60) @(posedge clk);
    apb(0, 8'h38, 32'h0); chk(rd, 32'h80);
    $display("test regs done");
  endtask

  task automatic trip_circuit_alarm_delay();
    apb(1, 8'h04, 32'h2);
    apb(1, 8'h00, 32'h05);
    wok <= 1'b0; repeat (5) @(posedge clk); wok <= 1'b1;
    repeat (20) @(posedge clk); chk(32'(tca), 32'h0);
    wok <= 1'b0; wt(0, 9, 13);
    brk <= 1'b0; repeat (4) @(posedge clk); chk(32'(tca), 32'h0);
    wok <= 1'b1; apb(1, 8'h00, 32'h07); sup <= 1'b0; wt(0, 9, 13);
    sup <= 1'b1; brk <= 1'b1; repeat (4) @(posedge clk); chk(32'(tca), 32'h0);
    $display("test tcs done");
  endtask

  task automatic t_cts();
    apb(1, 8'h00, 32'h08); apb(1, 8'h10, 32'h64);
    is0 <= {16'hFF06, 16'hFF06, 16'h01F4}; repeat (8) @(posedge clk);
    chk(32'(cta), 32'h0);
    is0[47:32] <= 16'h0000; wt(2, 1, 5);
    ig <= 16'hFE0C; repeat (4) @(posedge clk); chk(32'(cta), 32'h0);
    ig <= 16'h0000; wt(2, 1, 5);
    apb(1, 8'h14, 32'h100); repeat (4) @(posedge clk); chk(32'(cta), 32'h0);
    apb(1, 8'h00, 32'h00); is0 <= 48'h0;
    $display("test cts done");
  endtask

  task automatic t_lop();
    apb(1, 8'h28, 32'h3E8); apb(1, 8'h2C, 32'h64); apb(1, 8'h30, 32'h64);
    apb(1, 8'h08, 32'h1); apb(1, 8'h20, 32'h01); apb(1, 8'h24, 32'hA5);
    apb(1, 8'h00, 32'h34);
    vph[15:0] <= 16'h0005; wt(1, 5, 9);
    repeat (2) @(posedge clk); chk(32'(eb), 32'hA5);
    vph[15:0] <= 16'h03E8; repeat (4) @(posedge clk); chk({plb, eb}, 32'h0);
    v0 <= 16'h03E8; vph[15:0] <= 16'h0005;
    repeat (20) @(posedge clk); chk(32'(plb), 32'h0);
    v2 <= 16'h01F4; wt(1, 5, 9);
    oc <= 8'h01; v0 <= 16'h0000; v2 <= 16'h0000; vph[15:0] <= 16'h0005;
    repeat (20) @(posedge clk); chk(32'(plb), 32'h0);
    oc <= 8'h00; brk <= 1'b0;
    repeat (20) @(posedge clk); chk(32'(plb), 32'h0);
    apb(1, 8'h00, 32'h90); is0 <= {3{16'h00C8}}; wt(1, 5, 9);
    apb(1, 8'h00, 32'h14); brk <= 1'b1; is0 <= 48'h0; repeat (12) @(posedge clk);
    chk({plb, eb}, 32'h1_0000);
    apb(1, 8'h00, 32'h40); vph[15:0] <= 16'h03E8; fuse <= 1'b1;
    repeat (3) @(posedge clk); chk(32'(eb), 32'hA5);
    fuse <= 1'b0;
    $display("test lop done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // reset for three clocks, then the scenarios in turn
  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    brk = 1'b1; sup = 1'b1; wok = 1'b1; fuse = 1'b0; oc = 8'h00; ig = 16'h0;
    is0 = 48'h0; is1 = 48'h0; vph = {3{16'h03E8}}; v0 = 16'h0; v2 = 16'h0;
    error_cnt = 0; num_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    trip_circuit_alarm_delay();
    t_cts();
    t_lop();
    summarize();
  end
endmodule
